// ==== ffsp_defs.vh ====
/*
 * Constants for the flash fault status and protection block: register
 * offsets, field positions, reset values and range geometry.
 * Assumes a byte-wide register port and a 16-bit global flash address.
 */
`ifndef FFSP_DEFS_VH
`define FFSP_DEFS_VH

`define FFSP_ADDR_W          16
`define FFSP_OFF_FAULT       16'h3027
`define FFSP_OFF_PROT        16'h3028
`define FFSP_OFF_CTRL        16'h3029
`define FFSP_OFF_CMDSTAT     16'h302a

`define FFSP_FLT_SINGLE      0
`define FFSP_FLT_DOUBLE      1

`define FFSP_PROT_POL        7
`define FFSP_PROT_RSV        6
`define FFSP_PROT_HDIS       5
`define FFSP_PROT_HS_HI      4
`define FFSP_PROT_HS_LO      3
`define FFSP_PROT_LDIS       2
`define FFSP_PROT_LS_HI      1
`define FFSP_PROT_LS_LO      0

`define FFSP_CTRL_IGNORE_SINGLE_FAULT      0
`define FFSP_STAT_VIOL       4

`define FFSP_NV_PROT_ADDR    16'hff7c
`define FFSP_HIGH_END        16'hffff
`define FFSP_LOW_BASE        16'h8000

`define FFSP_ZERO8           8'h00
`define FFSP_ZERO16          16'h0000
`define FFSP_ONE16           16'h0001

`define FFSP_SIZE_0          16'h0400
`define FFSP_SIZE_1          16'h0800
`define FFSP_SIZE_2          16'h1000
`define FFSP_SIZE_3          16'h2000

`endif

// ==== ffsp_flash_fault_prot.v ====
/*
 * Flash fault status and sector protection registers.
 * Fault events arrive as one-cycle pulses from the flash read path on clk_in.
 * The protection byte is fetched once over a simple nonvolatile read port
 * after reset release; program/erase requests are checked against it.
 */
// Functional notes
// [R1] Fault status bits 7 to 2 always read zero.
// [R2] Double flag sets on two-bit error or read colliding with a command.
// [R3] Double flag clears only by writing one; zero is ignored.
// [R4] Single flag sets on collision, or on corrected error unless ignore is set.
// [R5] Single flag clears only by writing one; zero is ignored.
// [R6] A parity error reports single or double, never both.
// [R7] A read colliding with a running command sets both flags.
// [R8] Flags are stored one clock after the read; software waits one cycle.
// [R9] Protection writes are accepted only when they enlarge protection.
// [R10] Reset sequence loads protection from nonvolatile byte at 0xFF7C.
// [R11] Program or erase of protected area is refused and violation flag set.
// [R12] Whole-block erase refused when any sector in the block is protected.
// [R13] Polarity zero: enabled ranges are unprotected regions.
// [R14] Polarity one: enabled ranges are protected regions.
// [R15] Protection bit 6 always reads one.
// [R16] Bit 5 zero enables high range ending at 0xFFFF.
// [R17] High size field writable only while high range is disabled.
// [R18] Bit 2 zero enables low range starting at 0x8000.
// [R19] Low size field writable only while low range is disabled.
// [R20] Violation flag is write-one-clear and blocks command launch while set.
// [R21] Size code to byte count is a parameter; larger codes mean larger ranges.
`include "ffsp_defs.vh"
`default_nettype none

module ffsp_flash_fault_prot #(
    parameter [15:0] SIZE_C0 = `FFSP_SIZE_0,
    parameter [15:0] SIZE_C1 = `FFSP_SIZE_1,
    parameter [15:0] SIZE_C2 = `FFSP_SIZE_2,
    parameter [15:0] SIZE_C3 = `FFSP_SIZE_3
) (
    input  wire        clk_in,
    input  wire        rstn_in,
    input  wire [15:0] reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [7:0]  reg_rdata_out,
    input  wire        rd_single_err_in,
    input  wire        rd_double_err_in,
    input  wire        rd_collision_in,
    output reg         nv_rd_out,
    output reg  [15:0] nv_addr_out,
    input  wire        nv_valid_in,
    input  wire [7:0]  nv_data_in,
    output wire        init_done_out,
    input  wire        cmd_req_in,
    input  wire        cmd_erase_blk_in,
    input  wire        cmd_seq_start_in,
    input  wire [15:0] cmd_addr_in,
    input  wire [15:0] blk_base_in,
    input  wire [15:0] blk_end_in,
    output reg         cmd_accept_out,
    output reg         cmd_reject_out,
    output wire        seq_allowed_out,
    output wire        protection_violation_flag_out
);

    localparam [2:0] ST_FETCH = 3'b001;
    localparam [2:0] ST_WAIT  = 3'b010;
    localparam [2:0] ST_RUN   = 3'b100;

    reg  [2:0] state_q;
    reg        single_fault_flag_q;
    reg        double_fault_flag_q;
    reg        ignore_single_fault_q;
    reg        protection_violation_flag_q;
    reg        protection_polarity_q;
    reg        high_range_disable_q;
    reg  [1:0] high_range_size_q;
    reg        low_range_disable_q;
    reg  [1:0] low_range_size_q;

    wire wr_fault = reg_wr_in && (reg_addr_in == `FFSP_OFF_FAULT);
    wire wr_prot  = reg_wr_in && (reg_addr_in == `FFSP_OFF_PROT) && (state_q == ST_RUN);
    wire wr_ctrl  = reg_wr_in && (reg_addr_in == `FFSP_OFF_CTRL);
    wire wr_stat  = reg_wr_in && (reg_addr_in == `FFSP_OFF_CMDSTAT);

    wire hi_hit;
    wire hi_touch;
    wire hi_inside;
    wire lo_hit;
    wire lo_touch;
    wire lo_inside;

    ffsp_range_window #(
        .ANCHOR_TOP (1'b1),
        .ANCHOR     (`FFSP_HIGH_END),
        .SIZE_C0    (SIZE_C0),
        .SIZE_C1    (SIZE_C1),
        .SIZE_C2    (SIZE_C2),
        .SIZE_C3    (SIZE_C3)
    ) u_high_window (
        .enable_in      (!high_range_disable_q), // [R16]
        .size_code_in   (high_range_size_q),
        .addr_in        (cmd_addr_in),
        .blk_base_in    (blk_base_in),
        .blk_end_in     (blk_end_in),
        .addr_hit_out   (hi_hit),
        .blk_touch_out  (hi_touch),
        .blk_inside_out (hi_inside)
    );

    ffsp_range_window #(
        .ANCHOR_TOP (1'b0),
        .ANCHOR     (`FFSP_LOW_BASE),
        .SIZE_C0    (SIZE_C0),
        .SIZE_C1    (SIZE_C1),
        .SIZE_C2    (SIZE_C2),
        .SIZE_C3    (SIZE_C3)
    ) u_low_window (
        .enable_in      (!low_range_disable_q), // [R18]
        .size_code_in   (low_range_size_q),
        .addr_in        (cmd_addr_in),
        .blk_base_in    (blk_base_in),
        .blk_end_in     (blk_end_in),
        .addr_hit_out   (lo_hit),
        .blk_touch_out  (lo_touch),
        .blk_inside_out (lo_inside)
    );

    // Polarity one protects the enabled ranges; zero protects everything else.
    wire addr_prot = protection_polarity_q ? (hi_hit || lo_hit)
                                           : !(hi_hit || lo_hit); // [R13] [R14]

    // A block is clean only if no address of it is protected.
    wire blk_prot = protection_polarity_q ? (hi_touch || lo_touch)
                                          : !(hi_inside || lo_inside); // [R12]

    wire req_prot = cmd_erase_blk_in ? blk_prot : addr_prot;

    assign init_done_out                 = (state_q == ST_RUN);
    assign protection_violation_flag_out = protection_violation_flag_q;
    assign seq_allowed_out = init_done_out && !protection_violation_flag_q; // [R20]

    // Reset sequence fetches the protection byte before commands are taken.
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q     <= ST_FETCH;
            nv_rd_out   <= 1'b0;
            nv_addr_out <= `FFSP_ZERO16;
        end else begin
            case (state_q)
                ST_FETCH: begin
                    nv_rd_out   <= 1'b1;
                    nv_addr_out <= `FFSP_NV_PROT_ADDR; // [R10]
                    state_q     <= ST_WAIT;
                end
                ST_WAIT: begin
                    nv_rd_out <= 1'b0;
                    if (nv_valid_in) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    nv_rd_out <= 1'b0;
                end
                default: begin
                    state_q <= ST_FETCH;
                end
            endcase
        end
    end

    // Fault flags register the read-path pulses one clock later, so a status
    // read in the same cycle as a flash read still sees the old value.
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            single_fault_flag_q <= 1'b0;
            double_fault_flag_q <= 1'b0;
        end else begin
            // Set wins over a simultaneous write-one clear.
            if (rd_collision_in || (rd_single_err_in && !rd_double_err_in
                                    && !ignore_single_fault_q)) begin
                single_fault_flag_q <= 1'b1; // [R4] [R6] [R7] [R8]
            end else if (wr_fault && reg_wdata_in[`FFSP_FLT_SINGLE]) begin
                single_fault_flag_q <= 1'b0; // [R5]
            end
            if (rd_collision_in || rd_double_err_in) begin
                double_fault_flag_q <= 1'b1; // [R2] [R7] [R8]
            end else if (wr_fault && reg_wdata_in[`FFSP_FLT_DOUBLE]) begin
                double_fault_flag_q <= 1'b0; // [R3]
            end
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ignore_single_fault_q <= 1'b0;
        end else if (wr_ctrl) begin
            ignore_single_fault_q <= reg_wdata_in[`FFSP_CTRL_IGNORE_SINGLE_FAULT];
        end
    end

    // Protection register: loaded at init, then writable only to add protection.
    // Most protective state before the load completes: all ranges disabled
    // with polarity zero protects the whole array.
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            protection_polarity_q <= 1'b0;
            high_range_disable_q  <= 1'b1;
            high_range_size_q     <= 2'h0;
            low_range_disable_q   <= 1'b1;
            low_range_size_q      <= 2'h0;
        end else if (state_q == ST_WAIT && nv_valid_in) begin
            protection_polarity_q <= nv_data_in[`FFSP_PROT_POL]; // [R10]
            high_range_disable_q  <= nv_data_in[`FFSP_PROT_HDIS];
            high_range_size_q     <= nv_data_in[`FFSP_PROT_HS_HI:`FFSP_PROT_HS_LO];
            low_range_disable_q   <= nv_data_in[`FFSP_PROT_LDIS];
            low_range_size_q      <= nv_data_in[`FFSP_PROT_LS_HI:`FFSP_PROT_LS_LO];
        end else if (wr_prot) begin
            // Polarity one protects only ranges: enabling a range or growing its
            // size grows protection. Polarity zero is the reverse, so only
            // disabling a range or shrinking it adds protection.
            if (protection_polarity_q) begin
                if (!reg_wdata_in[`FFSP_PROT_HDIS]) begin
                    high_range_disable_q <= 1'b0; // [R9] [R16]
                end
                if (!reg_wdata_in[`FFSP_PROT_LDIS]) begin
                    low_range_disable_q <= 1'b0; // [R9] [R18]
                end
                if (high_range_disable_q &&
                    reg_wdata_in[`FFSP_PROT_HS_HI:`FFSP_PROT_HS_LO] > high_range_size_q) begin
                    high_range_size_q <= reg_wdata_in[`FFSP_PROT_HS_HI:`FFSP_PROT_HS_LO]; // [R17] [R21]
                end
                if (low_range_disable_q &&
                    reg_wdata_in[`FFSP_PROT_LS_HI:`FFSP_PROT_LS_LO] > low_range_size_q) begin
                    low_range_size_q <= reg_wdata_in[`FFSP_PROT_LS_HI:`FFSP_PROT_LS_LO]; // [R19] [R21]
                end
            end else begin
                if (reg_wdata_in[`FFSP_PROT_HDIS]) begin
                    high_range_disable_q <= 1'b1; // [R9]
                end
                if (reg_wdata_in[`FFSP_PROT_LDIS]) begin
                    low_range_disable_q <= 1'b1; // [R9]
                end
                if (high_range_disable_q &&
                    reg_wdata_in[`FFSP_PROT_HS_HI:`FFSP_PROT_HS_LO] < high_range_size_q) begin
                    high_range_size_q <= reg_wdata_in[`FFSP_PROT_HS_HI:`FFSP_PROT_HS_LO]; // [R17]
                end
                if (low_range_disable_q &&
                    reg_wdata_in[`FFSP_PROT_LS_HI:`FFSP_PROT_LS_LO] < low_range_size_q) begin
                    low_range_size_q <= reg_wdata_in[`FFSP_PROT_LS_HI:`FFSP_PROT_LS_LO]; // [R19]
                end
                // Going from open to protected polarity with nothing enabled
                // protects nothing, so it is refused; with a range enabled the
                // switch would unprotect the rest of the array, also refused.
            end
        end
    end

    // Command check and violation flag.
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            protection_violation_flag_q <= 1'b0;
            cmd_accept_out              <= 1'b0;
            cmd_reject_out              <= 1'b0;
        end else begin
            cmd_accept_out <= 1'b0;
            cmd_reject_out <= 1'b0;
            if (cmd_req_in && seq_allowed_out) begin
                if (req_prot) begin
                    cmd_reject_out              <= 1'b1; // [R11] [R12]
                    protection_violation_flag_q <= 1'b1; // [R11]
                end else begin
                    cmd_accept_out <= 1'b1;
                end
            end else if (cmd_req_in || cmd_seq_start_in) begin
                cmd_reject_out <= 1'b1; // [R20]
            end else if (wr_stat && reg_wdata_in[`FFSP_STAT_VIOL]) begin
                protection_violation_flag_q <= 1'b0; // [R20]
            end
        end
    end

    // Read data one cycle after the strobe; unmapped addresses read zero.
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= `FFSP_ZERO8;
        end else if (reg_rd_in) begin
            reg_rdata_out <= `FFSP_ZERO8; // [R1]
            case (reg_addr_in)
                `FFSP_OFF_FAULT: begin
                    reg_rdata_out[`FFSP_FLT_SINGLE] <= single_fault_flag_q;
                    reg_rdata_out[`FFSP_FLT_DOUBLE] <= double_fault_flag_q;
                end
                `FFSP_OFF_PROT: begin
                    reg_rdata_out[`FFSP_PROT_POL]  <= protection_polarity_q;
                    reg_rdata_out[`FFSP_PROT_RSV]  <= 1'b1; // [R15]
                    reg_rdata_out[`FFSP_PROT_HDIS] <= high_range_disable_q;
                    reg_rdata_out[`FFSP_PROT_HS_HI:`FFSP_PROT_HS_LO] <= high_range_size_q;
                    reg_rdata_out[`FFSP_PROT_LDIS] <= low_range_disable_q;
                    reg_rdata_out[`FFSP_PROT_LS_HI:`FFSP_PROT_LS_LO] <= low_range_size_q;
                end
                `FFSP_OFF_CTRL: begin
                    reg_rdata_out[`FFSP_CTRL_IGNORE_SINGLE_FAULT] <= ignore_single_fault_q;
                end
                `FFSP_OFF_CMDSTAT: begin
                    reg_rdata_out[`FFSP_STAT_VIOL] <= protection_violation_flag_q;
                end
                default: begin
                    reg_rdata_out <= `FFSP_ZERO8;
                end
            endcase
        end
    end

endmodule // ffsp_flash_fault_prot

// Address window of one protection range. The high range hangs down from the
// top of the array and the low range grows up from its base, so one module
// serves both; ANCHOR_TOP says which end of the window is fixed.
module ffsp_range_window #(
    parameter        ANCHOR_TOP = 1'b0,
    parameter [15:0] ANCHOR     = `FFSP_LOW_BASE,
    parameter [15:0] SIZE_C0    = `FFSP_SIZE_0,
    parameter [15:0] SIZE_C1    = `FFSP_SIZE_1,
    parameter [15:0] SIZE_C2    = `FFSP_SIZE_2,
    parameter [15:0] SIZE_C3    = `FFSP_SIZE_3
) (
    input  wire        enable_in,
    input  wire [1:0]  size_code_in,
    input  wire [15:0] addr_in,
    input  wire [15:0] blk_base_in,
    input  wire [15:0] blk_end_in,
    output wire        addr_hit_out,
    output wire        blk_touch_out,
    output wire        blk_inside_out
);

    reg  [15:0] size_bytes;
    wire [15:0] win_lo;
    wire [15:0] win_hi;

    // Larger size codes give larger windows while SIZE_C0 to SIZE_C3 increase, so the write filter can
    // compare codes instead of byte counts.
    always @* begin
        case (size_code_in)
            2'h0:    size_bytes = SIZE_C0; // [R21]
            2'h1:    size_bytes = SIZE_C1;
            2'h2:    size_bytes = SIZE_C2;
            default: size_bytes = SIZE_C3;
        endcase
    end

    // Inclusive window; sizes must stay below the anchor distance or it wraps.
    assign win_lo = ANCHOR_TOP ? (ANCHOR - size_bytes + `FFSP_ONE16) : ANCHOR;
    assign win_hi = ANCHOR_TOP ? ANCHOR : (ANCHOR + size_bytes - `FFSP_ONE16);

    assign addr_hit_out   = enable_in && (addr_in >= win_lo) && (addr_in <= win_hi);
    assign blk_touch_out  = enable_in && (blk_end_in >= win_lo) && (blk_base_in <= win_hi);
    assign blk_inside_out = enable_in && (blk_base_in >= win_lo) && (blk_end_in <= win_hi);

endmodule // ffsp_range_window

`default_nettype wire

// ==== ffsp_chk.sv ====
/*
 * Concurrent checks on the ports of the flash fault status and protection block.
 * Assumes one clock domain, reset low, and the register map of ffsp_defs.vh.
 */
`include "ffsp_defs.vh"
`default_nettype none
module ffsp_chk (
    input wire logic        clk_in,
    input wire logic        rstn_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        rd_collision_in,
    input wire logic        nv_rd_out,
    input wire logic [15:0] nv_addr_out,
    input wire logic        init_done_out,
    input wire logic        cmd_req_in,
    input wire logic        cmd_accept_out,
    input wire logic        cmd_reject_out,
    input wire logic        protection_violation_flag_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_fault_rsv_zero: assert property (
        reg_rd_in && reg_addr_in == `FFSP_OFF_FAULT |=> reg_rdata_out[7:2] == 6'h00)
        else $error("fault status reserved bits not zero");
    a_prot_rsv_one: assert property (
        reg_rd_in && reg_addr_in == `FFSP_OFF_PROT |=> reg_rdata_out[6])
        else $error("protection bit 6 not one");
    a_coll_both_flags: assert property (
        rd_collision_in ##1 (reg_rd_in && reg_addr_in == `FFSP_OFF_FAULT)
        |=> reg_rdata_out[1:0] == 2'b11) else $error("collision did not set both flags");
    a_nv_fetch_addr: assert property (
        nv_rd_out |-> nv_addr_out == `FFSP_NV_PROT_ADDR) else $error("wrong fetch address");
    a_cmd_one_answer: assert property (
        cmd_req_in |=> cmd_accept_out != cmd_reject_out) else $error("command answer wrong");
    a_viol_sets_flag: assert property (
        cmd_req_in && init_done_out ##1 cmd_reject_out |-> protection_violation_flag_out)
        else $error("reject without violation flag");
    a_viol_blocks_cmd: assert property (
        cmd_req_in && protection_violation_flag_out |=> cmd_reject_out)
        else $error("command accepted while violation set");
    a_viol_w1c_hold: assert property (
        protection_violation_flag_out && !(reg_wr_in && reg_addr_in == `FFSP_OFF_CMDSTAT
        && reg_wdata_in[4]) |=> protection_violation_flag_out) else $error("flag lost");
    a_no_cmd_early: assert property (
        cmd_req_in && !init_done_out |=> cmd_reject_out && $stable(protection_violation_flag_out))
        else $error("command handled before protection load");
endmodule // ffsp_chk
bind ffsp_flash_fault_prot ffsp_chk u_chk (.clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rd_collision_in, .nv_rd_out, .nv_addr_out,
    .init_done_out, .cmd_req_in, .cmd_accept_out, .cmd_reject_out, .protection_violation_flag_out);
`default_nettype wire

// ==== ffsp_flash_fault_prot_tb.sv ====
/*
 * Self-checking bench for the flash fault status and protection block.
 * Assumes ffsp_defs.vh on the include path and the checker bound to the design.
 */
`include "ffsp_defs.vh"
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ffsp_flash_fault_prot_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in, rstn_in, reg_wr_in, reg_rd_in, nv_valid_in, cmd_req_in;
    logic        rd_single_err_in, rd_double_err_in, rd_collision_in;
    logic        cmd_erase_blk_in, cmd_seq_start_in;
    logic [15:0] reg_addr_in, cmd_addr_in, blk_base_in, blk_end_in;
    logic [7:0]  reg_wdata_in, nv_data_in;
    wire  [7:0]  reg_rdata_out;
    wire  [15:0] nv_addr_out;
    wire         nv_rd_out, init_done_out, acc, rej, seq_allowed_out, viol;
    int          n_fail, total_checks, cyc, seed, prot, rdy_m, viol_m;
    logic [7:0]  pw [5] = '{8'h34, 8'h24, 8'h14, 8'h3f, 8'h10};
    logic [15:0] ta [5] = '{16'h7fff, 16'h8000, 16'h8fff, 16'hefff, 16'hffff};
    ffsp_flash_fault_prot uut (.clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .rd_single_err_in, .rd_double_err_in, .rd_collision_in,
        .nv_rd_out, .nv_addr_out, .nv_valid_in, .nv_data_in, .init_done_out, .cmd_req_in,
        .cmd_erase_blk_in, .cmd_seq_start_in, .cmd_addr_in, .blk_base_in, .blk_end_in,
        .cmd_accept_out(acc), .cmd_reject_out(rej), .seq_allowed_out,
        .protection_violation_flag_out(viol));
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 20000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 `CHK(reg_rdata_out, e)
        @(posedge clk_in);
    endtask
    function automatic int sz(input int c);
        return c == 0 ? `FFSP_SIZE_0 : c == 1 ? `FFSP_SIZE_1 : c == 2 ? `FFSP_SIZE_2 : `FFSP_SIZE_3;
    endfunction
    // True when [a,b] touches an enabled range.
    function automatic bit hit(input int a, input int b);
        return (!prot[5] && b > 'hffff - sz(prot[4:3])) ||
            (!prot[2] && b >= 'h8000 && a < 'h8000 + sz(prot[1:0]));
    endfunction
    // True when [a,b] lies wholly inside one enabled range.
    function automatic bit fit(input int a, input int b);
        return (!prot[5] && a > 'hffff - sz(prot[4:3])) ||
            (!prot[2] && a >= 'h8000 && b < 'h8000 + sz(prot[1:0]));
    endfunction
    task automatic cmd(input logic [15:0] a, input logic blk);
        bit x;
        int lo, hi;
        lo = blk ? {a[15:12], 12'h000} : a;
        hi = blk ? {a[15:12], 12'hfff} : a;
        blk_base_in <= lo[15:0];
        blk_end_in <= hi[15:0];
        x = !rdy_m || viol_m || (prot[7] ? hit(lo, hi) : !fit(lo, hi));
        cmd_addr_in <= a;
        cmd_erase_blk_in <= blk;
        cmd_req_in <= 1'b1;
        @(posedge clk_in);
        cmd_req_in <= 1'b0;
        viol_m = viol_m || (rdy_m && x);
        #1 `CHK(rej, x)
        `CHK(acc, !x)
        `CHK(viol, viol_m[0])
        `CHK(seq_allowed_out, rdy_m && !viol_m)
        @(posedge clk_in);
    endtask
    task automatic clr();
        cmd_seq_start_in <= 1'b1;
        @(posedge clk_in);
        cmd_seq_start_in <= 1'b0;
        #1 `CHK(rej, 1'b1)
        @(posedge clk_in);
        wr(`FFSP_OFF_CMDSTAT, 8'hef);
        #1 `CHK(viol, 1'b1)
        @(posedge clk_in);
        wr(`FFSP_OFF_CMDSTAT, 8'h10);
        viol_m = 0;
    endtask
    task automatic pwr(input logic [7:0] d);
        int n;
        n = prot;
        if (prot[5] && (prot[7] ? d[4:3] > prot[4:3] : d[4:3] < prot[4:3])) n[4:3] = d[4:3];
        if (prot[2] && (prot[7] ? d[1:0] > prot[1:0] : d[1:0] < prot[1:0])) n[1:0] = d[1:0];
        if (prot[7] ? !d[5] : d[5]) n[5] = d[5];
        if (prot[7] ? !d[2] : d[2]) n[2] = d[2];
        wr(`FFSP_OFF_PROT, d);
        prot = n;
        rchk(`FFSP_OFF_PROT, prot[7:0] | 8'h40);
    endtask
    task automatic boot(input logic [7:0] b);
        rstn_in <= 1'b0;
        repeat (16) @(posedge clk_in);
        rstn_in <= 1'b1;
        rdy_m = 0;
        viol_m = 0;
        @(posedge clk_in);
        #1 `CHK(nv_rd_out, 1'b1)
        `CHK(nv_addr_out, `FFSP_NV_PROT_ADDR)
        @(posedge clk_in);
        cmd(16'h9000, 1'b0);
        nv_valid_in <= 1'b1;
        nv_data_in <= b;
        @(posedge clk_in);
        nv_valid_in <= 1'b0;
        nv_data_in <= ~b;
        @(posedge clk_in);
        #1 `CHK(init_done_out, 1'b1)
        @(posedge clk_in);
        prot = b;
        rdy_m = 1;
        rchk(`FFSP_OFF_PROT, b | 8'h40);
    endtask
    task automatic fault(input logic [2:0] ev, input logic ign);
        logic [7:0] e;
        e = ev[2] ? 8'h03 : ev[1] ? 8'h02 : {7'h00, ev[0] && !ign};
        wr(`FFSP_OFF_CTRL, {7'h00, ign});
        {rd_collision_in, rd_double_err_in, rd_single_err_in} <= ev;
        @(posedge clk_in);
        {rd_collision_in, rd_double_err_in, rd_single_err_in} <= 3'b000;
        rchk(`FFSP_OFF_FAULT, e);
        wr(`FFSP_OFF_FAULT, 8'hfc);
        rchk(`FFSP_OFF_FAULT, e);
        wr(`FFSP_OFF_FAULT, 8'h03);
        rchk(`FFSP_OFF_FAULT, 8'h00);
    endtask
    task automatic cmds();
        for (int i = 0; i < 17; i++) begin
            logic [15:0] a;
            a = i < 5 ? ta[i] : 16'($random(seed)) | 16'h8000;
            cmd(a, i > 4 ? a[0] : i == 4);
            if (viol_m) clr();
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        seed = 32'h176f2f67;
        {rstn_in, reg_wr_in, reg_rd_in, nv_valid_in, cmd_req_in, cmd_erase_blk_in} = '0;
        {rd_single_err_in, rd_double_err_in, rd_collision_in, cmd_seq_start_in} = '0;
        {reg_addr_in, cmd_addr_in, blk_base_in, blk_end_in, reg_wdata_in, nv_data_in} = '0;
        boot(8'ha4);
        for (int i = 0; i < 16; i++) fault(i[2:0], i[3]);
        rchk(16'h3030, 8'h00);
        foreach (pw[i]) pwr(pw[i]);
        cmds();
        boot(8'h14);
        cmds();
        pwr(8'h2c);
        pwr(8'h80);
        cmds();
        summarize();
    end
endmodule // ffsp_flash_fault_prot_tb
`default_nettype wire
